// File: design/sar_adc_sequencer.sv
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module sar_adc_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [adc_seq_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [adc_seq_pkg::DATA_W-1:0] writedata,
    output logic [adc_seq_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    // rc oscillator, asynchronous
    input wire logic rc_osc,
    // converter core
    input wire logic [adc_seq_pkg::RES_W-1:0] core_result,
    output logic core_enable,
    output logic core_sample,
    output logic core_convert,
    output logic [3:0] mux_pos_select,
    output logic mux_neg_select,
    // sequence event
    output logic seq_done_flag
);
    import adc_seq_pkg::*;

    logic [DATA_W-1:0] ctrl_one_q, ctrl_two_q, ctrl_three_q, input_sel_q;
    logic [RES_W-1:0] buf_q [BUF_DEPTH];
    logic [2:0] rc_sync_q;
    logic rc_prev_q;
    logic [7:0] pre_cnt_q;
    logic tad_half_q;
    logic tad_tick;
    logic [4:0] tad_cnt_q;
    logic [3:0] smp_cnt_q;
    logic [3:0] ptr_q;
    logic half_q;
    logic use_b_q;
    logic sample_control_bit_prev_q;
    seq_state_t state_q;
    logic wr_ctrl_one, bus_hit_q;
    logic conv_end, sample_control_bit_fall, sample_control_bit_start;

    // field decode helper
    function automatic logic bit_of(input logic [DATA_W-1:0] r, input int idx);
        return r[idx];
    endfunction

    wire logic on_w = bit_of(ctrl_one_q, ON_BIT);
    wire logic [2:0] trig_w = ctrl_one_q[TRIG_LSB +: 3];
    wire logic auto_sample_bit_w = bit_of(ctrl_one_q, AUTO_SAMPLE_BIT_BIT);
    wire logic sample_control_bit_w = bit_of(ctrl_one_q, SAMPLE_CONTROL_BIT_BIT);
    wire logic dual_w = bit_of(ctrl_two_q, DUAL_BIT);
    wire logic alt_w = bit_of(ctrl_two_q, ALT_BIT);
    wire logic [3:0] samples_per_interrupt_w = ctrl_two_q[SAMPLES_PER_INTERRUPT_LSB +: 4];
    wire logic rcsel_w = bit_of(ctrl_three_q, RC_BIT);
    wire logic [4:0] auto_sample_clock_count_w = ctrl_three_q[AUTO_SAMPLE_CLOCK_COUNT_LSB +: 5];
    wire logic [7:0] pre_w = ctrl_three_q[PRE_LSB +: 8];

    // avalon: one wait cycle, answer on second edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_hit_q <= 1'b0;
        end else begin
            bus_hit_q <= (read | write) & ~bus_hit_q;
        end
    end
    assign wr_ctrl_one = write & bus_hit_q & (address == REG_CTRL_ONE);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
            readdata <= BAD_READ;
        end else begin
            waitrequest <= ~((read | write) & ~bus_hit_q);
            if (read & ~bus_hit_q) begin
                case (address)
                    REG_CTRL_ONE: readdata <= ctrl_one_q;
                    REG_CTRL_TWO: readdata <= {ctrl_two_q[DATA_W-1:HALF_BIT+1], half_q,
                                               ctrl_two_q[HALF_BIT-1:0]};
                    REG_CTRL_THREE: readdata <= ctrl_three_q;
                    REG_INPUT_SEL: readdata <= input_sel_q;
                    default: begin
                        if (address >= REG_RESULT) begin
                            readdata <= {22'h0, buf_q[{1'b0, address[2:0]}]};
                        end else begin
                            readdata <= BAD_READ;
                        end
                    end
                endcase
            end
        end
    end

    // control registers; hardware updates sample and done bits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_one_q <= 32'h0;
            ctrl_two_q <= 32'h0;
            ctrl_three_q <= 32'h0;
            input_sel_q <= 32'h0;
        end else begin
            if (write & bus_hit_q) begin
                case (address)
                    REG_CTRL_ONE: ctrl_one_q <= writedata;
                    REG_CTRL_TWO: ctrl_two_q <= writedata;
                    REG_CTRL_THREE: ctrl_three_q <= writedata;
                    REG_INPUT_SEL: input_sel_q <= writedata;
                    default: ;
                endcase
            end
            // hardware sets win over software writes
            if (sample_control_bit_start) begin
                ctrl_one_q[SAMPLE_CONTROL_BIT_BIT] <= 1'b1;
                ctrl_one_q[DONE_BIT] <= 1'b0;
            end
            if (state_q == ST_SAMPLE && trig_w == TRIG_AUTO && tad_tick
                && tad_cnt_q >= auto_sample_clock_count_w) begin
                ctrl_one_q[SAMPLE_CONTROL_BIT_BIT] <= 1'b0;
            end
            if (conv_end && smp_cnt_q == samples_per_interrupt_w) begin
                ctrl_one_q[DONE_BIT] <= 1'b1;
            end
            if (!on_w && !(wr_ctrl_one && writedata[ON_BIT])) begin
                ctrl_one_q[SAMPLE_CONTROL_BIT_BIT] <= 1'b0;
            end
        end
    end

    // rc clock: three-stage synchroniser, edge when stages two and three agree
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rc_sync_q <= 3'h0;
            rc_prev_q <= 1'b0;
        end else begin
            rc_sync_q <= {rc_sync_q[1:0], rc_osc};
            if (rc_sync_q[1] == rc_sync_q[2]) begin
                rc_prev_q <= rc_sync_q[2];
            end
        end
    end

    // conversion clock tick: rc rising edge or prescaled bus clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt_q <= 8'h0;
            tad_half_q <= 1'b0;
            tad_tick <= 1'b0;
        end else begin
            tad_tick <= 1'b0;
            if (!on_w) begin
                pre_cnt_q <= 8'h0;
                tad_half_q <= 1'b0;
            end else if (rcsel_w) begin
                tad_tick <= rc_sync_q[1] & rc_sync_q[2] & ~rc_prev_q;
            end else if (pre_cnt_q >= pre_w) begin
                pre_cnt_q <= 8'h0;
                tad_half_q <= ~tad_half_q;
                tad_tick <= tad_half_q;
            end else begin
                pre_cnt_q <= pre_cnt_q + 8'h1;
            end
        end
    end

    assign sample_control_bit_fall = sample_control_bit_prev_q & ~sample_control_bit_w;
    assign conv_end = (state_q == ST_CONVERT) && tad_tick
                      && (tad_cnt_q == 5'(CONV_TADS - 1));
    assign sample_control_bit_start = on_w && auto_sample_bit_w && (state_q == ST_IDLE) && !sample_control_bit_w;

    // acquire / convert sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            tad_cnt_q <= 5'h0;
            sample_control_bit_prev_q <= 1'b0;
        end else begin
            sample_control_bit_prev_q <= sample_control_bit_w;
            if (!on_w) begin
                state_q <= ST_IDLE;
                tad_cnt_q <= 5'h0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        tad_cnt_q <= 5'h0;
                        if (sample_control_bit_w) begin
                            state_q <= ST_SAMPLE;
                        end
                    end
                    ST_SAMPLE: begin
                        if (tad_tick && tad_cnt_q != 5'h1f) begin
                            tad_cnt_q <= tad_cnt_q + 5'h1;
                        end
                        if (trig_w == TRIG_AUTO && tad_tick && tad_cnt_q >= auto_sample_clock_count_w) begin
                            state_q <= ST_CONVERT;
                            tad_cnt_q <= 5'h0;
                        end else if (trig_w == TRIG_MANUAL && sample_control_bit_fall) begin
                            state_q <= ST_CONVERT;
                            tad_cnt_q <= 5'h0;
                        end
                    end
                    ST_CONVERT: begin
                        if (conv_end) begin
                            state_q <= ST_IDLE;
                            tad_cnt_q <= 5'h0;
                        end else if (tad_tick) begin
                            tad_cnt_q <= tad_cnt_q + 5'h1;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // buffer pointer, sample counter, half indicator, alternation
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            smp_cnt_q <= 4'h0;
            ptr_q <= 4'h0;
            half_q <= 1'b0;
            use_b_q <= 1'b0;
            seq_done_flag <= 1'b0;
        end else begin
            seq_done_flag <= 1'b0;
            if (!on_w) begin
                // module off: next sequence starts fresh at slot zero and mux a
                smp_cnt_q <= 4'h0;
                ptr_q <= 4'h0;
                half_q <= 1'b0;
                use_b_q <= 1'b0;
            end else if (conv_end) begin
                use_b_q <= alt_w & ~use_b_q;
                if (smp_cnt_q == samples_per_interrupt_w) begin
                    seq_done_flag <= 1'b1;
                    smp_cnt_q <= 4'h0;
                    use_b_q <= 1'b0;
                    if (dual_w) begin
                        half_q <= ~half_q;
                        ptr_q <= half_q ? 4'h0 : 4'(HALF_DEPTH);
                    end else begin
                        half_q <= 1'b0;
                        ptr_q <= 4'h0;
                    end
                end else begin
                    smp_cnt_q <= smp_cnt_q + 4'h1;
                    ptr_q <= ptr_q + 4'h1;
                end
            end
        end
    end

    // result storage at conversion end only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_q[i] <= 10'h0;
            end
        end else if (conv_end) begin
            buf_q[ptr_q] <= core_result;
        end
    end

    // core and mux drive
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_enable <= 1'b0;
            core_sample <= 1'b0;
            core_convert <= 1'b0;
            mux_pos_select <= 4'h0;
            mux_neg_select <= 1'b0;
        end else begin
            core_enable <= on_w;
            core_sample <= on_w && state_q == ST_SAMPLE;
            core_convert <= on_w && state_q == ST_CONVERT;
            if (use_b_q) begin
                mux_pos_select <= input_sel_q[B_POS_LSB +: 4];
                mux_neg_select <= bit_of(input_sel_q, B_NEG_BIT);
            end else begin
                mux_pos_select <= input_sel_q[A_POS_LSB +: 4];
                mux_neg_select <= bit_of(input_sel_q, A_NEG_BIT);
            end
        end
    end
endmodule // sar_adc_sequencer

// File: design/adc_seq_pkg.sv
package adc_seq_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;
    localparam int RES_W = 10;
    localparam int BUF_DEPTH = 16;
    localparam int HALF_DEPTH = 8;
    localparam int CONV_TADS = 12;
    // register word addresses
    localparam logic [ADDR_W-1:0] REG_CTRL_ONE = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CTRL_TWO = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CTRL_THREE = 4'h2;
    localparam logic [ADDR_W-1:0] REG_INPUT_SEL = 4'h3;
    localparam logic [ADDR_W-1:0] REG_RESULT = 4'h8;
    // control one fields
    localparam int ON_BIT = 15;
    localparam int TRIG_LSB = 5;
    localparam int AUTO_SAMPLE_BIT_BIT = 2;
    localparam int SAMPLE_CONTROL_BIT_BIT = 1;
    localparam int DONE_BIT = 0;
    // control two fields
    localparam int HALF_BIT = 7;
    localparam int SAMPLES_PER_INTERRUPT_LSB = 2;
    localparam int DUAL_BIT = 1;
    localparam int ALT_BIT = 0;
    // control three fields
    localparam int RC_BIT = 15;
    localparam int AUTO_SAMPLE_CLOCK_COUNT_LSB = 8;
    localparam int PRE_LSB = 0;
    // input select fields
    localparam int A_POS_LSB = 16;
    localparam int A_NEG_BIT = 23;
    localparam int B_POS_LSB = 24;
    localparam int B_NEG_BIT = 31;
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    localparam logic [DATA_W-1:0] BAD_READ = 32'h0000_0000;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_t;
endpackage

// File: test/sar_adc_sequencer_sva.sv
`timescale 1ns/10ps
module adc_seq_checker (
    // watched ports
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [adc_seq_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [adc_seq_pkg::DATA_W-1:0] writedata,
    input wire logic waitrequest,
    input wire logic core_enable,
    input wire logic core_sample,
    input wire logic core_convert,
    input wire logic [3:0] mux_pos_select,
    input wire logic mux_neg_select,
    input wire logic seq_done_flag
);
    import adc_seq_pkg::*;
    logic [7:0] pre_q;
    logic [4:0] auto_sample_clock_count_q;
    logic rc_q;
    logic auto_sample_bit_q;
    logic [2:0] trig_q;
    logic [15:0] ccnt_q;
    logic [15:0] scnt_q;
    logic [15:0] per;
    // bus clocks per conversion clock tick
    assign per = ({8'h00, pre_q} + 16'h0001) << 1;
    // shadow of the timing settings taken by the slave
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_q <= 8'h00;
            auto_sample_clock_count_q <= 5'h00;
            rc_q <= 1'b0;
            auto_sample_bit_q <= 1'b0;
            trig_q <= 3'h0;
        end else if (write && !waitrequest && address == REG_CTRL_THREE) begin
            rc_q <= writedata[RC_BIT];
            auto_sample_clock_count_q <= writedata[AUTO_SAMPLE_CLOCK_COUNT_LSB+:5];
            pre_q <= writedata[PRE_LSB+:8];
        end else if (write && !waitrequest && address == REG_CTRL_ONE) begin
            auto_sample_bit_q <= writedata[AUTO_SAMPLE_BIT_BIT];
            trig_q <= writedata[TRIG_LSB+:3];
        end
    end
    // lengths of the convert and sample phases
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ccnt_q <= 16'h0000;
            scnt_q <= 16'h0000;
        end else begin
            ccnt_q <= core_convert ? ccnt_q + 16'h0001 : 16'h0000;
            scnt_q <= core_sample ? scnt_q + 16'h0001 : 16'h0000;
        end
    end
    sequence conv_end;
        core_convert ##1 !core_convert;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer one cycle after request");
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_off_quiet: assert property (!core_enable |-> !core_sample && !core_convert)
        else $error("core active while disabled");
    a_done_pulse: assert property (seq_done_flag |=> !seq_done_flag)
        else $error("sequence flag longer than one cycle");
    a_done_cause: assert property (seq_done_flag |-> $past(core_convert) || $past(core_convert, 2))
        else $error("sequence flag without conversion end");
    a_end_converts: assert property ($fell(core_sample) && core_enable |-> ##[0:2] core_convert)
        else $error("sampling ended without conversion");
    a_mux_hold: assert property (core_convert && $past(core_convert) |->
        $stable(mux_pos_select) && $stable(mux_neg_select))
        else $error("input select moved during conversion");
    a_auto_resample: assert property (conv_end ##0 (auto_sample_bit_q && core_enable) |-> ##[0:3] core_sample)
        else $error("no new acquisition after conversion");
    a_conv_len: assert property ($fell(core_convert) && core_enable && !rc_q |->
        ccnt_q >= 11 * per && ccnt_q <= 12 * per + 2)
        else $error("conversion length off");
    a_sample_control_bit_len: assert property ($fell(core_sample) && core_enable && !rc_q && trig_q == TRIG_AUTO
        |-> scnt_q >= auto_sample_clock_count_q * per && scnt_q <= (auto_sample_clock_count_q + 1) * per + 2)
        else $error("auto sample length off");
endmodule // adc_seq_checker

bind sar_adc_sequencer adc_seq_checker u_chk (.clk(clk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest),
    .core_enable(core_enable), .core_sample(core_sample), .core_convert(core_convert),
    .mux_pos_select(mux_pos_select), .mux_neg_select(mux_neg_select),
    .seq_done_flag(seq_done_flag));

// File: test/adc_core_model.sv
`timescale 1ns/10ps
module adc_core_model (
    // converter core side
    input wire logic clk,
    input wire logic core_sample,
    input wire logic core_convert,
    input wire logic [3:0] mux_pos_select,
    input wire logic mux_neg_select,
    output logic [9:0] core_result
);
    logic [9:0] held_q;
    logic [9:0] noise_q = 10'h155;
    logic conv_q;
    // track the input while sampling, keep it through conversion
    always_ff @(posedge clk) begin
        if (core_sample) begin
            held_q <= {mux_neg_select, mux_pos_select, 5'h0a};
        end
        conv_q <= core_convert;
        noise_q <= noise_q + 10'h001;
    end
    // result stands during conversion and for one cycle after it, moves otherwise
    assign core_result = (core_convert || conv_q) ? held_q : ~held_q ^ noise_q;
endmodule // adc_core_model

// File: test/sar_adc_sequencer_tb.sv
`timescale 1ns/10ps
module sar_adc_sequencer_tb;
    import adc_seq_pkg::*;
    logic clk, sys_rst, read, write, rc_osc, waitrequest, core_enable, core_sample;
    logic core_convert, mux_neg_select, seq_done_flag, an, bn, alt, dual;
    logic [3:0] address, mux_pos_select, ap, bp;
    logic [31:0] writedata, readdata, q;
    logic [9:0] core_result;
    logic [7:0] pre;
    int n_fail, n_tests, seed, n, k, m, c;
    sar_adc_sequencer dut (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .rc_osc(rc_osc), .core_result(core_result), .core_enable(core_enable),
        .core_sample(core_sample), .core_convert(core_convert),
        .mux_pos_select(mux_pos_select), .mux_neg_select(mux_neg_select),
        .seq_done_flag(seq_done_flag));
    adc_core_model core (.clk(clk), .core_sample(core_sample), .core_convert(core_convert),
        .mux_pos_select(mux_pos_select), .mux_neg_select(mux_neg_select),
        .core_result(core_result));
    // clocks: bus clock and unrelated rc oscillator
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rc_osc = 1'b0;
        #3;
        forever #50 rc_osc = ~rc_osc;
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task results;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (waitrequest !== 1'b0 && i < 50);
        q = readdata;
        chk("waitrequest", 32'h0, {31'h0, waitrequest});
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // wait for the sequence flag, counting conversions started (rising edges of core_convert)
    task wait_done(output int cnt);
        int i;
        logic pc;
        i = 0;
        cnt = 0;
        pc = core_convert;
        do begin
            @(posedge clk);
            if (pc === 1'b0 && core_convert === 1'b1) cnt++;
            pc = core_convert;
            i++;
        end while (seq_done_flag !== 1'b1 && i < 3000);
        chk("seq done", 32'h1, {31'h0, seq_done_flag});
    endtask
    task cfg(input logic [31:0] c1, input logic [31:0] c2, input logic [31:0] c3);
        bus(1'b1, REG_CTRL_ONE, 32'h0);
        bus(1'b1, REG_INPUT_SEL, {bn, 3'h0, bp, an, 3'h0, ap, 16'h0});
        bus(1'b1, REG_CTRL_TWO, c2);
        bus(1'b1, REG_CTRL_THREE, c3);
        bus(1'b1, REG_CTRL_ONE, c1);
    endtask
    function automatic logic [31:0] exp_res(input int j);
        if (alt && j % 2 == 1) return {22'h0, bn, bp, 5'h0a};
        return {22'h0, an, ap, 5'h0a};
    endfunction
    // watchdog
    initial begin
        #300000;
        n_fail++;
        results;
    end
    // main sequence
    initial begin
        seed = 93955;
        n_fail = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        {read, write, address, writedata} = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, 4'h5, 32'h0);
        chk("unmapped", 32'h0, q);
        for (m = 0; m < 3; m++) begin
            {ap, bp, an, bn} = 10'($random(seed));
            n = 3 + 2 * ({$random(seed)} % 3);
            dual = (m == 1);
            alt = (m != 1);
            pre = 8'h04 + 8'({$random(seed)} % 3);
            cfg({16'h0, 1'b1, 7'h0, TRIG_AUTO, 5'h04}, {24'h0, 2'h0, 4'(n - 1), dual, alt},
                {19'h0, 5'(m + 1), pre});
            wait_done(c);
            chk("conversions", n, c);
            bus(1'b0, REG_CTRL_TWO, 32'h0);
            if (dual) chk("half", 32'h1, {31'h0, q[HALF_BIT]});
            wait_done(c);
            chk("conversions", n, c);
            bus(1'b0, REG_CTRL_TWO, 32'h0);
            chk("half", 32'h0, {31'h0, q[HALF_BIT]});
            for (k = 0; k < n; k++) begin
                bus(1'b0, REG_RESULT + 4'(k), 32'h0);
                chk("result", exp_res(k), q);
            end
        end
        alt = 1'b0;
        cfg(32'h0000_8000, 32'h0, 32'h0000_8000);
        repeat (4) @(posedge clk);
        bus(1'b1, REG_CTRL_ONE, 32'h0000_8002);
        repeat (8) @(posedge clk);
        chk("enable", 32'h1, {31'h0, core_enable});
        chk("sampling", 32'h1, {31'h0, core_sample});
        chk("mux a", {27'h0, an, ap}, {27'h0, mux_neg_select, mux_pos_select});
        bus(1'b1, REG_CTRL_ONE, 32'h0000_8000);
        wait_done(c);
        chk("conversions", 32'h1, c);
        bus(1'b0, REG_CTRL_ONE, 32'h0);
        chk("done bit", 32'h1, {31'h0, q[DONE_BIT]});
        bus(1'b0, REG_RESULT, 32'h0);
        chk("result", exp_res(0), q);
        bus(1'b1, REG_CTRL_ONE, 32'h0);
        repeat (4) @(posedge clk);
        chk("enable", 32'h0, {31'h0, core_enable});
        results;
    end
endmodule // sar_adc_sequencer_tb
